// ---- verilog/digipot_serial_command_logic.sv ----
/*
  Serial command interpreter of a digital rheostat: link-side shift logic on
  the serial clock, command decoding, wiper register, control flags and a
  fifty-entry one-time store on the system clock.
  Assumes a host that holds frame select low across whole 16-bit multiples
  and stops the serial clock while frame select is high; an external
  pull-up on the open-drain serial output.
*/
`timescale 1ns/100ps
`include "digipot_defs.svh"

module digipot_serial_command_logic
  import digipot_pkg::*;
#(
  parameter int STORE_CYCLES = `STORE_CYCLES,
  parameter int STORE_DEPTH  = `STORE_DEPTH
) (
  // system clock and reset
  input  wire logic       clk_i,
  input  wire logic       sys_rst_i,
  // serial link from the host
  input  wire logic       sclk_i,
  input  wire logic       sync_n_i,
  input  wire logic       din_i,
  // open-drain serial output
  output logic            serial_out_o,
  output logic            serial_out_oe_o,
  // analogue side
  output logic [9:0]      wiper_register_o,
  output logic            shutdown_o,
  output logic            calibration_disable_flag_o,
  output logic            store_busy_o
);

  // --------------------------------------------------------------------------
  // elaboration checks
  // --------------------------------------------------------------------------
  if (STORE_DEPTH < 1 || STORE_DEPTH > 63) begin : g_bad_depth
    $error("store depth must fit a six-bit address");
  end
  if (STORE_CYCLES < 1) begin : g_bad_cycles
    $error("store time must be at least one cycle");
  end

  // --------------------------------------------------------------------------
  // link side, serial clock domain
  // --------------------------------------------------------------------------
  logic [15:0] in_shift;      // last sixteen bits received
  logic [7:0]  bit_count;     // bits in the current or last frame
  logic        frame_restart; // preset while frame select is high
  logic        out_bit;

  // restart marker; preset by the frame's own select so no clock is needed
  always_ff @(negedge sclk_i or posedge sync_n_i) begin
    if (sync_n_i) begin
      frame_restart <= 1'b1;
    end else begin
      frame_restart <= 1'b0;
    end
  end

  // sample data on the falling edge, opposite to the output change
  always_ff @(negedge sclk_i) begin
    in_shift <= {in_shift[14:0], din_i};
  end

  // count bits; held between frames so the system side can judge length
  always_ff @(negedge sclk_i) begin
    if (frame_restart) begin
      bit_count <= 8'h01;
    end else if (bit_count != 8'hFF) begin
      bit_count <= bit_count + 8'h01;
    end
  end

  // quasi-static words from the system side, only changed between frames
  logic [15:0] rb_word;
  logic        rb_pending;
  logic        out_released;

  // next output bit: readback in the first word, else the delayed input
  always_comb begin
    logic [7:0] idx;
    idx = frame_restart ? 8'h00 : bit_count;
    if (rb_pending && idx < 8'h10) begin
      out_bit = rb_word[4'hF - idx[3:0]];
    end else begin
      out_bit = in_shift[15];
    end
  end

  // open-drain driver, updated on the rising edge; idle released
  always_ff @(posedge sclk_i or posedge sync_n_i) begin
    if (sync_n_i) begin
      serial_out_oe_o <= 1'b0;
    end else begin
      serial_out_oe_o <= !out_bit && !out_released;
    end
  end

  // the pin only ever pulls low
  always_ff @(posedge clk_i) begin
    serial_out_o <= 1'b0;
  end

  // --------------------------------------------------------------------------
  // frame select synchroniser and end-of-frame detect
  // --------------------------------------------------------------------------
  logic sync_meta;
  logic sync_sync;
  logic sync_last;
  logic frame_end;

  // two stages before anything looks at the pin
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      sync_meta <= 1'b1;
      sync_sync <= 1'b1;
      sync_last <= 1'b1;
    end else begin
      sync_meta <= sync_n_i;
      sync_sync <= sync_meta;
      sync_last <= sync_sync;
    end
  end

  assign frame_end = sync_sync && !sync_last;

  // --------------------------------------------------------------------------
  // command decode
  // --------------------------------------------------------------------------
  frame_type        frame;
  logic             frame_whole;
  logic             frame_take;
  store_state_type  store_state;
  logic [31:0]      store_timer;
  logic [5:0]       last_addr;
  logic [3:0]       ctrl_flags;
  logic             release_armed;
  logic [9:0]       store_mem [1:STORE_DEPTH];

  // shift register and count are frozen while frame select is high
  assign frame       = frame_type'(in_shift);
  assign frame_whole = (bit_count[3:0] == 4'h0) && (bit_count != 8'h00);
  // nothing shifted in during a store is acted upon
  assign frame_take  = frame_end && frame_whole && (store_state == ST_IDLE);

  // stored value picked by a read command's low data bits
  logic [5:0] sel_addr;
  logic [9:0] sel_value;
  assign sel_addr = frame.data[5:0];

  always_comb begin
    sel_value = 10'h000;
    if (sel_addr >= `STORE_FIRST_ADDR && sel_addr <= 6'(STORE_DEPTH)) begin
      sel_value = store_mem[sel_addr];
    end
  end

  // --------------------------------------------------------------------------
  // wiper register
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      wiper_register_o <= `WIPER_MIDSCALE;
    end else if (frame_take) begin
      case (frame.cmd)
        `CMD_WIPER_WRITE: begin
          if (ctrl_flags[`CTRL_WIPER_WE]) begin
            wiper_register_o <= frame.data;
          end
        end
        `CMD_SOFT_RESET: begin
          if (last_addr == 6'h00) begin
            wiper_register_o <= `WIPER_MIDSCALE;
          end else begin
            wiper_register_o <= store_mem[last_addr];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // control flags
  // --------------------------------------------------------------------------
  // low three flags written by software; success set only by the store
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ctrl_flags <= `CTRL_RESET;
    end else begin
      if (frame_take && frame.cmd == `CMD_CTRL_WRITE) begin
        ctrl_flags[2:0] <= frame.data[2:0];
      end
      if (store_state == ST_STORING && store_timer == 32'd1) begin
        ctrl_flags[`CTRL_PROG_OK] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      calibration_disable_flag_o <= 1'b0;
    end else begin
      calibration_disable_flag_o <= ctrl_flags[`CTRL_CAL_DIS];
    end
  end

  // --------------------------------------------------------------------------
  // shutdown
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      shutdown_o <= 1'b0;
    end else if (frame_take) begin
      if (frame.cmd == `CMD_SHUTDOWN) begin
        shutdown_o <= frame.data[0];
      end else if (frame.cmd == `CMD_SOFT_RESET) begin
        shutdown_o <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // store sequencer
  // --------------------------------------------------------------------------
  // a full store is refused silently; the success flag simply stays as it was
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      store_state <= ST_IDLE;
      store_timer <= 32'd0;
      last_addr   <= 6'h00;
    end else begin
      case (store_state)
        ST_IDLE: begin
          if (frame_take && frame.cmd == `CMD_STORE && ctrl_flags[`CTRL_PROG_EN]
              && last_addr < 6'(STORE_DEPTH)) begin
            store_state <= ST_STORING;
            store_timer <= 32'(STORE_CYCLES);
          end
        end
        ST_STORING: begin
          store_timer <= store_timer - 32'd1;
          if (store_timer == 32'd1) begin
            store_state <= ST_IDLE;
            last_addr   <= last_addr + 6'h01;
          end
        end
        default: begin
          store_state <= ST_IDLE;
        end
      endcase
    end
  end

  // the fuse array keeps no reset; its fill pointer records what is valid
  always_ff @(posedge clk_i) begin
    if (store_state == ST_STORING && store_timer == 32'd1) begin
      store_mem[last_addr + 6'h01] <= wiper_register_o;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      store_busy_o <= 1'b0;
    end else begin
      store_busy_o <= (store_state == ST_STORING) && (store_timer != 32'd1);
    end
  end

  // --------------------------------------------------------------------------
  // readback words; changed only at frame end, read during the next frame
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rb_pending <= 1'b0;
      rb_word    <= 16'h0000;
    end else if (frame_take) begin
      rb_pending <= 1'b1;
      case (frame.cmd)
        `CMD_WIPER_READ: begin
          rb_word <= {6'h00, wiper_register_o};
        end
        `CMD_STORE_READ: begin
          rb_word <= {6'h00, sel_value};
        end
        `CMD_LAST_ADDR: begin
          rb_word <= {10'h000, last_addr};
        end
        `CMD_CTRL_READ: begin
          rb_word <= {12'h000, ctrl_flags};
        end
        default: begin
          rb_pending <= 1'b0;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // output release sequence
  // --------------------------------------------------------------------------
  // any frame other than the no-op word takes the output back into service
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      release_armed <= 1'b0;
      out_released  <= 1'b0;
    end else if (frame_take) begin
      release_armed <= (in_shift == `WORD_OUT_RELEASE);
      if (release_armed && in_shift == `WORD_NOP) begin
        out_released <= 1'b1;
      end else if (in_shift != `WORD_NOP) begin
        out_released <= 1'b0;
      end
    end
  end

endmodule : digipot_serial_command_logic

// ---- verilog/digipot_defs.svh ----
/*
  Constants for the serial command logic of the digital rheostat: frame layout,
  command codes, control flag positions, reset values and timing counts.
  Assumes it is included by bare name from files under verilog/.
*/
`ifndef DIGIPOT_DEFS_SVH
`define DIGIPOT_DEFS_SVH

// ----------------------------------------------------------------------------
// frame layout
// ----------------------------------------------------------------------------
`define FRAME_BITS        16
`define CMD_MSB           13
`define CMD_LSB           10
`define DATA_MSB          9
`define DATA_LSB          0

// ----------------------------------------------------------------------------
// command codes
// ----------------------------------------------------------------------------
`define CMD_NOP           4'h0
`define CMD_WIPER_WRITE   4'h1
`define CMD_WIPER_READ    4'h2
`define CMD_STORE         4'h3
`define CMD_SOFT_RESET    4'h4
`define CMD_STORE_READ    4'h5
`define CMD_LAST_ADDR     4'h6
`define CMD_CTRL_WRITE    4'h7
`define CMD_CTRL_READ     4'h8
`define CMD_SHUTDOWN      4'h9

// ----------------------------------------------------------------------------
// special words
// ----------------------------------------------------------------------------
`define WORD_OUT_RELEASE  16'h8001
`define WORD_NOP          16'h0000

// ----------------------------------------------------------------------------
// control flags, fields and reset values
// ----------------------------------------------------------------------------
`define CTRL_PROG_EN      0
`define CTRL_WIPER_WE     1
`define CTRL_CAL_DIS      2
`define CTRL_PROG_OK      3
`define CTRL_RESET        4'h0
`define WIPER_MIDSCALE    10'h200
`define STORE_DEPTH       50
`define STORE_FIRST_ADDR  6'h01

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define CLK_FREQ_HZ       20000000
`define STORE_TIME_MS     350
`define STORE_CYCLES      ((`STORE_TIME_MS * `CLK_FREQ_HZ + 999) / 1000)

`endif

// ---- verilog/digipot_pkg.sv ----
/*
  Types shared by the rheostat serial command logic.
  Assumes digipot_defs.svh supplies the numeric constants.
*/
package digipot_pkg;

  // one received 16-bit frame
  typedef struct packed {
    logic [1:0] spare;
    logic [3:0] cmd;
    logic [9:0] data;
  } frame_type;

  // store sequencer states
  typedef enum logic [0:0] {
    ST_IDLE,
    ST_STORING
  } store_state_type;

endpackage : digipot_pkg

// ---- verif/digipot_cmd_monitor.sv ----
/*
  Port checker of the rheostat command logic, bound into the design.
  Assumes every check can be sampled on clk_i with sys_rst_i.
*/
`timescale 1ns/100ps
module digipot_cmd_monitor #(
  parameter int STORE_CYCLES = 20
) (
  // system clock and reset
  input wire logic       clk_i,
  input wire logic       sys_rst_i,
  // watched ports
  input wire logic       sync_n_i,
  input wire logic       serial_out_o,
  input wire logic       serial_out_oe_o,
  input wire logic [9:0] wiper_register_o,
  input wire logic       shutdown_o,
  input wire logic       calibration_disable_flag_o,
  input wire logic       store_busy_o
);
  int busy_cnt;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  // length of the current busy span, read at its fall
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || !store_busy_o) begin
      busy_cnt <= 0;
    end else begin
      busy_cnt <= busy_cnt + 1;
    end
  end

  out_low_a: assert property (serial_out_o == 1'b0)
    else $error("serial data not low");
  oe_frame_a: assert property (serial_out_oe_o |-> !sync_n_i)
    else $error("serial output pulled outside a frame");
  wiper_hold_a: assert property ((!sync_n_i) [*8] |=> $stable(wiper_register_o))
    else $error("wiper moved inside a frame");
  shut_hold_a: assert property ((!sync_n_i) [*8] |=> $stable(shutdown_o))
    else $error("shutdown moved inside a frame");
  cal_hold_a: assert property ((!sync_n_i) [*8] |=> $stable(calibration_disable_flag_o))
    else $error("calibration flag moved inside a frame");
  // busy rises one cycle after the sequencer starts and falls with it
  store_len_a: assert property ($fell(store_busy_o) |-> busy_cnt == STORE_CYCLES - 1)
    else $error("store span wrong length");
  busy_lock_a: assert property (store_busy_o && $past(store_busy_o) |->
    $stable(wiper_register_o) && $stable(shutdown_o))
    else $error("state changed during store");
  reset_vals_a: assert property ($past(sys_rst_i) |->
    wiper_register_o == 10'h200 && !shutdown_o && !store_busy_o)
    else $error("wrong state after reset");
endmodule : digipot_cmd_monitor

bind digipot_serial_command_logic digipot_cmd_monitor #(.STORE_CYCLES(STORE_CYCLES))
  i_digipot_cmd_monitor (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .sync_n_i(sync_n_i),
  .serial_out_o(serial_out_o), .serial_out_oe_o(serial_out_oe_o),
  .wiper_register_o(wiper_register_o), .shutdown_o(shutdown_o),
  .calibration_disable_flag_o(calibration_disable_flag_o), .store_busy_o(store_busy_o));

// ---- verif/digipot_host_model.sv ----
/*
  Host side of the serial link: sends frames of any bit count up to 32.
  Assumes a pull-up on the open-drain serial output line.
*/
`timescale 1ns/100ps
module digipot_host_model (
  // link to the device
  output logic      sclk_o,
  output logic      sync_n_o,
  output logic      din_o,
  input wire logic  serial_out_i,
  input wire logic  serial_out_oe_i
);
  logic line;

  // pull-up wins unless the device pulls low
  assign line = (serial_out_oe_i && !serial_out_i) ? 1'b0 : 1'b1;

  // clock idles low and stands still between frames
  // a real rising select edge at start presets the link-side flops
  initial begin
    sclk_o = 1'b0;
    sync_n_o = 1'b0;
    din_o = 1'b0;
    #1 sync_n_o = 1'b1;
  end

  // msb first, 32 ns bit time; line sampled on the falling edge
  task automatic xfer(input logic [31:0] w, input int nbits, input int gap,
                      output logic [31:0] rx);
    rx = '0;
    sync_n_o = 1'b0;
    for (int k = nbits - 1; k >= 0; k--) begin
      din_o = w[k];
      #8 sclk_o = 1'b1;
      #16 rx = {rx[30:0], line};
      sclk_o = 1'b0;
      #8;
    end
    #16 sync_n_o = 1'b1;
    din_o = ~din_o; // stale data would hide a sampling slip
    #(gap); // the default gap outlasts a store
  endtask : xfer
endmodule : digipot_host_model

// ---- verif/digipot_serial_command_logic_test.sv ----
/*
  Self-checking bench of the rheostat serial command logic.
  Assumes the host model frames every word and a shortened store time.
*/
`timescale 1ns/100ps
module digipot_serial_command_logic_test;
  localparam int STORE_CYCLES = 20;
  typedef struct packed {
    logic [15:0] word;
    logic [15:0] back;
    logic [9:0]  wiper;
  } row_type;
  logic        clk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic        sclk_i, sync_n_i, din_i, serial_out_o, serial_out_oe_o;
  logic        shutdown_o, calibration_disable_flag_o, store_busy_o;
  logic [9:0]  wiper_register_o;
  logic [31:0] rx;
  int          errors = 0;
  int          n_checks = 0;
  // word sent, word returned while it is sent, wiper afterwards
  row_type rows [11] = '{'{16'h0000, 16'h0000, 10'h200}, '{16'h0555, 16'h0000, 10'h200},
    '{16'h1C03, 16'h0555, 10'h200}, '{16'h0500, 16'h1C03, 10'h100},
    '{16'h0800, 16'h0500, 10'h100}, '{16'h0C00, 16'h0100, 10'h100},
    '{16'h1800, 16'h0C00, 10'h100}, '{16'h0000, 16'h0001, 10'h100},
    '{16'h1401, 16'h0000, 10'h100}, '{16'h2000, 16'h0100, 10'h100},
    '{16'h0000, 16'h000B, 10'h100}};

  always #25 clk_i = ~clk_i;

  digipot_serial_command_logic #(.STORE_CYCLES(STORE_CYCLES)) i_digipot_serial_command_logic (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .sclk_i(sclk_i), .sync_n_i(sync_n_i),
    .din_i(din_i), .serial_out_o(serial_out_o), .serial_out_oe_o(serial_out_oe_o),
    .wiper_register_o(wiper_register_o), .shutdown_o(shutdown_o),
    .calibration_disable_flag_o(calibration_disable_flag_o), .store_busy_o(store_busy_o));
  digipot_host_model i_digipot_host_model (
    .sclk_o(sclk_i), .sync_n_o(sync_n_i), .din_o(din_i),
    .serial_out_i(serial_out_o), .serial_out_oe_i(serial_out_oe_o));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR at %0t: seen 0x%0h expected 0x%0h", $time, seen, exp);
    end
  endtask : check

  // shutdown, calibration, idle store and wiper in one compare
  task automatic st(input logic sh, input logic cal, input logic [9:0] w);
    check({19'h0, shutdown_o, calibration_disable_flag_o, store_busy_o, wiper_register_o},
      {19'h0, sh, cal, 1'b0, w});
  endtask : st

  // start on a falling clock edge so link edges never meet a rising one
  task automatic send(input logic [31:0] w, input int n = 16, input int gap = 1500);
    @(negedge clk_i);
    i_digipot_host_model.xfer(w, n, gap, rx);
  endtask : send

  task automatic do_reset;
    @(posedge clk_i) sys_rst_i <= 1'b1;
    repeat (16) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask : do_reset

  task automatic summarize;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : summarize

  // watchdog well past the roughly 67 us of traffic
  initial begin
    #300000;
    errors++;
    summarize();
  end

  // table rows, then awkward cases
  initial begin
    do_reset();
    st(1'b0, 1'b0, 10'h200);
    send(32'h2000);
    foreach (rows[i]) begin
      send({16'h0, rows[i].word});
      check(rx, {16'h0, rows[i].back});
      st(1'b0, 1'b0, rows[i].wiper);
    end
    send(32'h2401);
    st(1'b1, 1'b0, 10'h100);
    send(32'h0480);
    st(1'b1, 1'b0, 10'h080);
    send(32'h1000);
    st(1'b0, 1'b0, 10'h100);
    send(32'h2401);
    send(32'h2400);
    st(1'b0, 1'b0, 10'h100);
    // a wiper write that ends while a store runs must be dropped
    send(32'h0C00, 16, 300);
    check(store_busy_o, 32'h1);
    send(32'h0455);
    st(1'b0, 1'b0, 10'h100);
    send(32'h1C07);
    st(1'b0, 1'b1, 10'h100);
    send(32'h1C03);
    send(32'h0123_04AA, 32);
    check(rx, 32'h1C03_0123);
    st(1'b0, 1'b0, 10'h0AA);
    send(32'h1_0555, 17);
    st(1'b0, 1'b0, 10'h0AA);
    send(32'h8001);
    send(32'h0000);
    send(32'h0000);
    check(rx, 32'hFFFF);
    do_reset();
    send(32'h1C02);
    send(32'h0555);
    send(32'h0C00);
    send(32'h1000);
    st(1'b0, 1'b0, 10'h200);
    send(32'h1800);
    send(32'h0000);
    check(rx, 32'h0000);
    summarize();
  end
endmodule : digipot_serial_command_logic_test
